// >>> hw/cpu_core.sv
// 8-bit Harvard processor core with a Wishbone control slave
// Overview of operation
// - Fetch next word while current one executes
// - Thirty-two 8-bit registers, single-cycle access
// - Two-operand ALU op reads, computes, writes back
// - Three register pairs act as pointers
// - One pointer pair addresses flash tables
// - Register, immediate and single-register ALU forms
// - Arithmetic, logical and bit-manipulation classes
// - Every ALU operation except move and swap updates status flags
// - One-word and two-word instruction formats
// - Jumps and calls reach whole program space
// - Boot and application sections, separate locks
// - Flash self write only from boot section
// - Calls and interrupts stack return address
// - Stack top pointer visible in I/O space
// - Five data addressing modes
// - Lowest vector wins among pending interrupts
// - Global enable flag gates interrupt acceptance
// - 64 I/O addresses at data 0x20-0x5F
// - Status flags not saved on interrupts
// - Interrupt entry clears enable, interrupt return sets
// - Stack moves one per byte, two per address
// - Sign flag equals negative xor overflow
//
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "cpu_core_map.svh"
module cpu_core (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Program memory
	output logic [15:0] pm_addr_o,
	input wire logic [15:0] pm_data_i,
	// Data memory and external I/O
	output logic [15:0] dm_addr_o,
	output logic [7:0] dm_wdata_o,
	output logic dm_we_o,
	output logic dm_re_o,
	input wire logic [7:0] dm_rdata_i,
	// Interrupt sources
	input wire logic [7:0] irq_i,
	output logic irq_ack_o,
	output logic [2:0] irq_num_o,
	// Flash self write port
	output logic flash_we_o,
	output logic [15:0] flash_addr_o,
	output logic [15:0] flash_data_o
);
	cpu_core_pkg::state_t state_reg, state_next; // Sequencer
	logic [15:0] instruction_fetch_counter_reg; // Word being fetched
	logic [15:0] ifc_next;
	logic [15:0] fetch_reg; // Address of word on pm_data_i
	logic valid_reg, valid_next; // pm_data_i holds a live word
	logic [15:0] ir_reg; // First word of multi-cycle op
	logic [15:0] resume_reg, resume_next; // Where to refetch
	logic [7:0] rethi_reg, rethi_next; // High return byte
	logic [4:0] ldrd_reg, ldrd_next; // Load destination
	logic [7:0] rf [32]; // Working registers
	logic [7:0] sreg_reg, sreg_next; // Status flags
	logic [15:0] stack_top_pointer_reg, stp_next;
	logic [7:0] ien_reg, ien_next; // Per-source enables
	logic [7:0] ctrl_reg; // Run and lock bits
	logic [15:0] dm_addr_next;
	logic [7:0] dm_wd_next;
	logic dm_we_next, dm_re_next;
	logic fw_next, ack_irq_next;
	logic [2:0] irq_num_next;
	logic rf_we, pw_we; // Byte and pointer write ports
	logic [4:0] rf_wa;
	logic [7:0] rf_wd;
	logic [1:0] pw_sel;
	logic [15:0] pw_val;
	logic acc, acc_st; // Data space access request
	logic [4:0] acc_rd;
	logic [15:0] ea; // Effective data address
	logic [7:0] iov; // Core I/O read value
	logic use_alu;
	logic [3:0] fn;
	logic [7:0] opa, opb;
	logic [4:0] rdi;
	logic [15:0] alu_out;
	logic [15:0] ptr, zp, ret;
	logic [7:0] pend, tb;
	logic [15:0] iw;
	logic core_io;

	assign iw = pm_data_i;
	assign pend = irq_i & ien_reg;
	assign pm_addr_o = instruction_fetch_counter_reg;
	assign zp = {rf[5'd31], rf[5'd30]};

	// Program address falls in the boot section
	function automatic logic in_boot(input logic [15:0] a);
		in_boot = (a >= `BOOT_START);
	endfunction

	// Pointer pair 1..3: index of its low register
	function automatic logic [4:0] pair_lo(input logic [1:0] p);
		pair_lo = {2'b11, p, 1'b0};
	endfunction

	// Lowest pending source index
	function automatic logic [2:0] prio(input logic [7:0] p);
		prio = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (p[i]) prio = i[2:0];
		end
	endfunction

	// ALU: returns new flags in 15:8 and result in 7:0
	function automatic logic [15:0] alu(input logic [3:0] f,
		input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] sr);
		logic [7:0] x, y, r, s;
		logic [8:0] sum;
		logic [4:0] h;
		logic ci, sb, v;
		s = sr;
		x = a;
		y = b;
		ci = 1'b0;
		sb = (f == `F_SUB) || (f == `F_SBC) || (f == `F_NEG);
		// Subtraction adds the inverted operand
		case (f)
			`F_ADC: ci = sr[`SR_C];
			`F_SUB: begin y = ~b; ci = 1'b1; end
			`F_SBC: begin y = ~b; ci = ~sr[`SR_C]; end
			`F_NEG: begin x = 8'h00; y = ~a; ci = 1'b1; end
			`F_INC: y = 8'h01;
			`F_DEC: y = 8'hff;
			default: ci = 1'b0;
		endcase
		sum = {1'b0, x} + {1'b0, y} + {8'h00, ci};
		h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
		r = sum[7:0];
		v = (x[7] == y[7]) && (r[7] != x[7]);
		// Arithmetic, logical and bit class results
		case (f)
			`F_ADD, `F_ADC, `F_SUB, `F_SBC, `F_NEG: begin
				s[`SR_C] = sum[8] ^ sb;
				s[`SR_H] = h[4] ^ sb;
				s[`SR_V] = v;
			end
			`F_INC, `F_DEC: s[`SR_V] = v;
			`F_AND: begin r = a & b; s[`SR_V] = 1'b0; end
			`F_OR: begin r = a | b; s[`SR_V] = 1'b0; end
			`F_EOR: begin r = a ^ b; s[`SR_V] = 1'b0; end
			`F_MOV: r = b;
			`F_COM: begin
				r = ~a;
				s[`SR_V] = 1'b0;
				s[`SR_C] = 1'b1;
			end
			`F_LSR: begin r = {1'b0, a[7:1]}; s[`SR_C] = a[0]; end
			`F_ROR: begin
				r = {sr[`SR_C], a[7:1]};
				s[`SR_C] = a[0];
			end
			`F_ASR: begin r = {a[7], a[7:1]}; s[`SR_C] = a[0]; end
			default: r = {a[3:0], a[7:4]};
		endcase
		// Moves and nibble swaps leave the flags alone
		if (f != `F_MOV && f != `F_SWAP) begin
			s[`SR_N] = r[7];
			s[`SR_Z] = (r == 8'h00);
			if (f >= `F_LSR) s[`SR_V] = r[7] ^ s[`SR_C];
			s[`SR_S] = s[`SR_N] ^ s[`SR_V];
		end
		alu = {s, r};
	endfunction

	// Core-resident I/O locations
	always_comb begin
		core_io = 1'b1;
		case (ea)
			`IO_SREG: iov = sreg_reg;
			`IO_SPH: iov = stack_top_pointer_reg[15:8];
			`IO_SPL: iov = stack_top_pointer_reg[7:0];
			`IO_IEN: iov = ien_reg;
			default: begin iov = 8'h00; core_io = 1'b0; end
		endcase
	end

	// Decode and sequencing
	always_comb begin
		state_next = state_reg;
		ifc_next = instruction_fetch_counter_reg;
		valid_next = valid_reg;
		resume_next = resume_reg;
		rethi_next = rethi_reg;
		ldrd_next = ldrd_reg;
		sreg_next = sreg_reg;
		stp_next = stack_top_pointer_reg;
		ien_next = ien_reg;
		dm_addr_next = dm_addr_o;
		dm_wd_next = dm_wdata_o;
		dm_we_next = 1'b0;
		dm_re_next = 1'b0;
		fw_next = 1'b0;
		ack_irq_next = 1'b0;
		irq_num_next = irq_num_o;
		rf_we = 1'b0;
		rf_wa = 5'h00;
		rf_wd = 8'h00;
		pw_we = 1'b0;
		pw_sel = 2'h1;
		pw_val = 16'h0000;
		acc = 1'b0;
		acc_st = 1'b0;
		acc_rd = iw[4:0];
		ea = 16'h0000;
		use_alu = 1'b0;
		fn = `F_ADD;
		opa = rf[iw[4:0]];
		opb = rf[iw[4:0]];
		rdi = iw[4:0];
		alu_out = 16'h0000;
		ptr = {rf[pair_lo(iw[10:9]) + 5'h1], rf[pair_lo(iw[10:9])]};
		ret = fetch_reg + 16'h1;
		tb = zp[0] ? iw[15:8] : iw[7:0];
		case (state_reg)
			cpu_core_pkg::S_EXEC: begin
				if (!ctrl_reg[`CTRL_RUN]) begin
					// Halted: refetch the same word later
					ifc_next = valid_reg ? fetch_reg :
						instruction_fetch_counter_reg;
					valid_next = 1'b0;
				end else if (!valid_reg) begin
					ifc_next = instruction_fetch_counter_reg + 16'h1;
					valid_next = 1'b1;
				end else if (sreg_reg[`SR_I] && |pend) begin
					// Prior instruction done; this one waits
					irq_num_next = prio(pend);
					ack_irq_next = 1'b1;
					dm_we_next = 1'b1;
					dm_addr_next = stack_top_pointer_reg;
					dm_wd_next = fetch_reg[7:0];
					stp_next = stack_top_pointer_reg - 16'h1;
					rethi_next = fetch_reg[15:8];
					resume_next = `VEC_BASE +
						{12'h000, prio(pend), 1'b0};
					sreg_next[`SR_I] = 1'b0;
					valid_next = 1'b0;
					state_next = cpu_core_pkg::S_PUSHH;
				end else begin
					// Next word already on its way
					ifc_next = instruction_fetch_counter_reg + 16'h1;
					valid_next = 1'b1;
					if (iw[15:14] == 2'b01) begin
						// Register with immediate
						use_alu = 1'b1;
						rdi = {1'b1, iw[11:8]};
						opa = rf[{1'b1, iw[11:8]}];
						opb = iw[7:0];
						case (iw[13:12])
							2'h0: fn = `F_SUB;
							2'h1: fn = `F_AND;
							2'h2: fn = `F_OR;
							default: fn = `F_MOV;
						endcase
					end else if (iw[15:13] == 3'b001) begin
						// Two registers
						use_alu = 1'b1;
						fn = {1'b0, iw[12:10]};
						rdi = iw[9:5];
						opa = rf[iw[9:5]];
						opb = rf[iw[4:0]];
					end else begin
						case (iw[15:12])
							`OP_UNARY: begin
								if (!iw[11]) begin
									use_alu = 1'b1;
									fn = {1'b1, iw[10:8]};
								end else if (iw[11:8] == `U_BST) begin
									sreg_next[`SR_T] = rf[iw[4:0]][iw[7:5]];
								end else if (iw[11:8] == `U_BLD) begin
									rf_we = 1'b1;
									rf_wa = iw[4:0];
									rf_wd = rf[iw[4:0]];
									rf_wd[iw[7:5]] = sreg_reg[`SR_T];
								end else if (iw[11:8] == `U_PUSH) begin
									dm_we_next = 1'b1;
									dm_addr_next = stack_top_pointer_reg;
									dm_wd_next = rf[iw[4:0]];
									stp_next = stack_top_pointer_reg -
										16'h1;
								end else begin
									dm_re_next = 1'b1;
									dm_addr_next = stack_top_pointer_reg +
										16'h1;
									stp_next = dm_addr_next;
									ldrd_next = iw[4:0];
									resume_next = instruction_fetch_counter_reg;
									valid_next = 1'b0;
									state_next = cpu_core_pkg::S_LDW;
								end
							end
							`OP_MEM: begin
								if (iw[10:9] == 2'h0) begin
									state_next = cpu_core_pkg::S_WORD2;
								end else begin
									// Pointer modes
									acc = 1'b1;
									acc_st = iw[11];
									pw_sel = iw[10:9];
									case (iw[8:7])
										2'h0: ea = ptr;
										2'h1: begin
											ea = ptr;
											pw_we = 1'b1;
											pw_val = ptr + 16'h1;
										end
										2'h2: begin
											ea = ptr - 16'h1;
											pw_we = 1'b1;
											pw_val = ea;
										end
										default: ea = ptr + {14'h0, iw[6:5]};
									endcase
								end
							end
							`OP_IO: begin
								acc = 1'b1;
								acc_st = iw[11];
								ea = `IO_BASE + {10'h000, iw[10:5]};
							end
							`OP_JMP, `OP_CALL, `OP_CJMP:
								state_next = cpu_core_pkg::S_WORD2;
							`OP_MISC: begin
								case (iw[3:0])
									`M_RET, `M_IRET: begin
										dm_re_next = 1'b1;
										dm_addr_next = stack_top_pointer_reg +
											16'h1;
										valid_next = 1'b0;
										state_next = cpu_core_pkg::S_RETW;
									end
									`M_SEI: sreg_next[`SR_I] = 1'b1;
									`M_CLI: sreg_next[`SR_I] = 1'b0;
									`M_SELFWR: fw_next = in_boot(fetch_reg) &&
										!(in_boot(zp) ? ctrl_reg[`CTRL_BLOCK] :
										ctrl_reg[`CTRL_ALOCK]);
									`M_TBLRD: begin
										ifc_next = {1'b0, zp[15:1]};
										resume_next = instruction_fetch_counter_reg;
										valid_next = 1'b0;
										state_next = cpu_core_pkg::S_LPMW;
									end
									default: valid_next = 1'b1;
								endcase
							end
							default: valid_next = 1'b1;
						endcase
					end
					if (use_alu) begin
						alu_out = alu(fn, opa, opb, sreg_reg);
						rf_we = 1'b1;
						rf_wa = rdi;
						rf_wd = alu_out[7:0];
						sreg_next = alu_out[15:8];
					end
				end
			end
			cpu_core_pkg::S_WORD2: begin
				// Second word is on pm_data_i now
				ifc_next = instruction_fetch_counter_reg + 16'h1;
				valid_next = 1'b1;
				state_next = cpu_core_pkg::S_EXEC;
				case (ir_reg[15:12])
					`OP_JMP: begin
						ifc_next = iw;
						valid_next = 1'b0;
					end
					`OP_CJMP: begin
						if (sreg_reg[ir_reg[10:8]] == ir_reg[11]) begin
							ifc_next = iw;
							valid_next = 1'b0;
						end
					end
					`OP_CALL: begin
						dm_we_next = 1'b1;
						dm_addr_next = stack_top_pointer_reg;
						dm_wd_next = ret[7:0];
						stp_next = stack_top_pointer_reg - 16'h1;
						rethi_next = ret[15:8];
						resume_next = iw;
						ifc_next = instruction_fetch_counter_reg;
						valid_next = 1'b0;
						state_next = cpu_core_pkg::S_PUSHH;
					end
					default: begin
						acc = 1'b1;
						acc_st = ir_reg[11];
						acc_rd = ir_reg[4:0];
						ea = iw;
					end
				endcase
			end
			cpu_core_pkg::S_PUSHH: begin
				dm_we_next = 1'b1;
				dm_addr_next = stack_top_pointer_reg;
				dm_wd_next = rethi_reg;
				stp_next = stack_top_pointer_reg - 16'h1;
				ifc_next = resume_reg;
				valid_next = 1'b0;
				state_next = cpu_core_pkg::S_EXEC;
			end
			cpu_core_pkg::S_LDW: state_next = cpu_core_pkg::S_LDC;
			cpu_core_pkg::S_LDC: begin
				rf_we = 1'b1;
				rf_wa = ldrd_reg;
				rf_wd = dm_rdata_i;
				ifc_next = resume_reg;
				valid_next = 1'b0;
				state_next = cpu_core_pkg::S_EXEC;
			end
			cpu_core_pkg::S_RETW: begin
				dm_re_next = 1'b1;
				dm_addr_next = stack_top_pointer_reg + 16'h2;
				state_next = cpu_core_pkg::S_RETH;
			end
			cpu_core_pkg::S_RETH: begin
				rethi_next = dm_rdata_i;
				state_next = cpu_core_pkg::S_RETL;
			end
			cpu_core_pkg::S_RETL: begin
				ifc_next = {rethi_reg, dm_rdata_i};
				stp_next = stack_top_pointer_reg + 16'h2;
				if (ir_reg[3:0] == `M_IRET) sreg_next[`SR_I] = 1'b1;
				valid_next = 1'b0;
				state_next = cpu_core_pkg::S_EXEC;
			end
			cpu_core_pkg::S_LPMW: state_next = cpu_core_pkg::S_LPMC;
			cpu_core_pkg::S_LPMC: begin
				// Cross-section reads obey the read lock
				rf_we = 1'b1;
				rf_wa = 5'h00;
				rf_wd = tb;
				if (in_boot(zp) != in_boot(resume_reg - 16'h1) &&
					(in_boot(zp) ? ctrl_reg[`CTRL_BLOCK + 1] :
					ctrl_reg[`CTRL_ALOCK + 1])) rf_wd = 8'h00;
				ifc_next = resume_reg;
				valid_next = 1'b0;
				state_next = cpu_core_pkg::S_EXEC;
			end
			default: state_next = cpu_core_pkg::S_EXEC;
		endcase
		// Data space access: registers, core I/O, then bus
		if (acc) begin
			if (ea <= `RF_END) begin
				rf_we = 1'b1;
				rf_wa = acc_st ? ea[4:0] : acc_rd;
				rf_wd = acc_st ? rf[acc_rd] : rf[ea[4:0]];
			end else if (core_io) begin
				if (!acc_st) begin
					rf_we = 1'b1;
					rf_wa = acc_rd;
					rf_wd = iov;
				end else if (ea == `IO_SREG) begin
					sreg_next = rf[acc_rd];
				end else if (ea == `IO_SPH) begin
					stp_next[15:8] = rf[acc_rd];
				end else if (ea == `IO_SPL) begin
					stp_next[7:0] = rf[acc_rd];
				end else begin
					ien_next = rf[acc_rd];
				end
			end else begin
				dm_addr_next = ea;
				dm_wd_next = rf[acc_rd];
				dm_we_next = acc_st;
				dm_re_next = !acc_st;
				if (!acc_st) begin
					// Loads from the bus stall and refetch
					ldrd_next = acc_rd;
					resume_next = instruction_fetch_counter_reg;
					ifc_next = instruction_fetch_counter_reg;
					valid_next = 1'b0;
					state_next = cpu_core_pkg::S_LDW;
				end
			end
		end
	end

	// Fetch pipeline and sequencer state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= cpu_core_pkg::S_EXEC;
			instruction_fetch_counter_reg <= 16'h0000;
			fetch_reg <= 16'h0000;
			valid_reg <= 1'b0;
			ir_reg <= 16'h0000;
		end else begin
			state_reg <= state_next;
			instruction_fetch_counter_reg <= ifc_next;
			fetch_reg <= instruction_fetch_counter_reg;
			valid_reg <= valid_next;
			if (state_reg == cpu_core_pkg::S_EXEC) ir_reg <= iw;
		end
	end

	// Sequencer scratch registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			resume_reg <= 16'h0000;
			rethi_reg <= 8'h00;
			ldrd_reg <= 5'h00;
		end else begin
			resume_reg <= resume_next;
			rethi_reg <= rethi_next;
			ldrd_reg <= ldrd_next;
		end
	end

	// Working registers: pointer port, then byte port
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 32; i++) rf[i] <= 8'h00;
		end else begin
			if (pw_we) begin
				rf[pair_lo(pw_sel)] <= pw_val[7:0];
				rf[pair_lo(pw_sel) + 5'h1] <= pw_val[15:8];
			end
			if (rf_we) rf[rf_wa] <= rf_wd;
		end
	end

	// Flags, stack top and enables; stack starts at zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sreg_reg <= 8'h00;
			stack_top_pointer_reg <= 16'h0000;
			ien_reg <= 8'h00;
		end else begin
			sreg_reg <= sreg_next;
			stack_top_pointer_reg <= stp_next;
			ien_reg <= ien_next;
		end
	end

	// Registered memory, interrupt and flash outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dm_addr_o <= 16'h0000;
			dm_wdata_o <= 8'h00;
			dm_we_o <= 1'b0;
			dm_re_o <= 1'b0;
			irq_ack_o <= 1'b0;
			irq_num_o <= 3'h0;
			flash_we_o <= 1'b0;
			flash_addr_o <= 16'h0000;
			flash_data_o <= 16'h0000;
		end else begin
			dm_addr_o <= dm_addr_next;
			dm_wdata_o <= dm_wd_next;
			dm_we_o <= dm_we_next;
			dm_re_o <= dm_re_next;
			irq_ack_o <= ack_irq_next;
			irq_num_o <= irq_num_next;
			flash_we_o <= fw_next;
			if (fw_next) begin
				flash_addr_o <= zp;
				flash_data_o <= {rf[5'd1], rf[5'd0]};
			end
		end
	end

	// Wishbone slave: ack one cycle after the request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
			ctrl_reg <= `CTRL_RST;
		end else begin
			ack_o <= cyc_i && stb_i && !ack_o;
			if (cyc_i && stb_i && !ack_o) begin
				case (adr_i[7:2])
					`WB_CTRL: dat_o <= {24'h000000, ctrl_reg};
					`WB_STAT: dat_o <= {8'h00, sreg_reg,
						instruction_fetch_counter_reg};
					`WB_STACK: dat_o <= {16'h0000, stack_top_pointer_reg};
					default: dat_o <= 32'h00000000;
				endcase
			end
			// Write lands on the acknowledging edge
			if (cyc_i && stb_i && ack_o && we_i && sel_i[0] &&
				adr_i[7:2] == `WB_CTRL) ctrl_reg <= dat_i[7:0];
		end
	end
endmodule

// >>> hw/cpu_core_map.svh
// Offsets, field positions, reset values and encodings of the core
`ifndef CPU_CORE_MAP_SVH
`define CPU_CORE_MAP_SVH
// Bus register word indexes (byte address = index * 4)
`define WB_CTRL 6'h00
`define WB_STAT 6'h01
`define WB_STACK 6'h02
// Control register fields and reset value
`define CTRL_RUN 0
`define CTRL_BLOCK 2
`define CTRL_ALOCK 4
`define CTRL_RST 8'h01
// Data space map
`define RF_END 16'h001f
`define IO_BASE 16'h0020
`define IO_SREG 16'h005f
`define IO_SPH 16'h005e
`define IO_SPL 16'h005d
`define IO_IEN 16'h005b
// Flash sections and vectors
`define BOOT_START 16'hf000
`define VEC_BASE 16'h0002
// Status flag bit positions
`define SR_I 7
`define SR_T 6
`define SR_H 5
`define SR_S 4
`define SR_V 3
`define SR_N 2
`define SR_Z 1
`define SR_C 0
// Major opcodes in bits 15:12
`define OP_MISC 4'h0
`define OP_UNARY 4'h1
`define OP_MEM 4'h8
`define OP_IO 4'h9
`define OP_JMP 4'hc
`define OP_CALL 4'hd
`define OP_CJMP 4'he
// Misc sub-codes in bits 3:0
`define M_RET 4'h1
`define M_IRET 4'h2
`define M_SEI 4'h3
`define M_CLI 4'h4
`define M_SELFWR 4'h5
`define M_TBLRD 4'h6
// Unary sub-codes 8..11 in bits 11:8
`define U_BST 4'h8
`define U_BLD 4'h9
`define U_PUSH 4'ha
`define U_POP 4'hb
// ALU functions
`define F_ADD 4'h0
`define F_ADC 4'h1
`define F_SUB 4'h2
`define F_SBC 4'h3
`define F_AND 4'h4
`define F_OR 4'h5
`define F_EOR 4'h6
`define F_MOV 4'h7
`define F_COM 4'h8
`define F_NEG 4'h9
`define F_INC 4'ha
`define F_DEC 4'hb
`define F_LSR 4'hc
`define F_ROR 4'hd
`define F_ASR 4'he
`define F_SWAP 4'hf
`endif

// >>> hw/cpu_core_pkg.sv
// Types shared by the processor core
package cpu_core_pkg;
	// Sequencer states
	typedef enum logic [3:0] {
		S_EXEC, S_WORD2, S_PUSHH, S_LDW, S_LDC,
		S_RETW, S_RETH, S_RETL, S_LPMW, S_LPMC
	} state_t;
endpackage

// >>> bench/cpu_core_monitor.sv
// Port checker for the processor core
`timescale 1ns/1ps
module cpu_core_monitor (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	// Memories
	input wire logic [15:0] pm_addr_o,
	input wire logic [15:0] dm_addr_o,
	input wire logic dm_we_o,
	input wire logic dm_re_o,
	// Interrupts
	input wire logic [7:0] irq_i,
	input wire logic irq_ack_o,
	input wire logic [2:0] irq_num_o
);
	// One domain, reset masks everything
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Any data bus access
	wire logic bus_use = dm_we_o || dm_re_o;
	ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("bus answer late");
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	rf_internal_a: assert property (bus_use |-> dm_addr_o > 16'h001f)
		else $error("register file address on bus");
	io_internal_a: assert property (bus_use |->
		!(dm_addr_o inside {16'h005b, 16'h005d, 16'h005e, 16'h005f}))
		else $error("internal io address on bus");
	irq_prio_a: assert property (irq_ack_o |->
		($past(irq_i) & ((8'h01 << irq_num_o) - 8'h01)) == 8'h00)
		else $error("higher priority source skipped");
	irq_src_a: assert property (irq_ack_o |->
		(($past(irq_i) >> irq_num_o) & 8'h01) == 8'h01)
		else $error("ack without request");
	irq_push_a: assert property (irq_ack_o |-> dm_we_o ##1
		(dm_we_o && dm_addr_o == $past(dm_addr_o) - 16'h0001))
		else $error("return address not stacked");
	irq_vector_a: assert property (irq_ack_o |-> ##1
		pm_addr_o == 16'h0002 + {12'h000, irq_num_o, 1'b0})
		else $error("vector fetch wrong");
	irq_once_a: assert property (irq_ack_o |=> !irq_ack_o [*3])
		else $error("interrupt re-entered at once");
endmodule
bind cpu_core cpu_core_monitor mon_u (.clk_i, .rst_i, .cyc_i, .stb_i,
	.ack_o, .pm_addr_o, .dm_addr_o, .dm_we_o, .dm_re_o, .irq_i,
	.irq_ack_o, .irq_num_o);

// >>> bench/cpu_mem_model.sv
// Program ROM and data RAM facing the core
`timescale 1ns/1ps
module cpu_mem_model (
	// Clock
	input wire logic clk_i,
	// Program side
	input wire logic [15:0] pm_addr_i,
	output logic [15:0] pm_data_o,
	// Data side
	input wire logic [15:0] dm_addr_i,
	input wire logic [7:0] dm_wdata_i,
	input wire logic dm_we_i,
	input wire logic dm_re_i,
	output logic [7:0] dm_rdata_o
);
	// Program words, loaded by the bench
	logic [15:0] rom [0:255];
	// Data bytes, stack area included
	logic [7:0] ram [0:65535];
	// Known start so junk differs from real data
	initial dm_rdata_o = 8'h5a;
	// Synchronous fetch, one cycle late
	always @(posedge clk_i) begin
		pm_data_o <= rom[pm_addr_i[7:0]];
	end
	// Stores land at the edge
	always @(posedge clk_i) begin
		if (dm_we_i) begin
			ram[dm_addr_i] <= dm_wdata_i;
		end
	end
	// Read data one cycle, else toggling junk
	always @(posedge clk_i) begin
		if (dm_re_i) begin
			dm_rdata_o <= ram[dm_addr_i];
		end else begin
			dm_rdata_o <= ~dm_rdata_o;
		end
	end
endmodule

// >>> bench/tb_cpu_core.sv
// Self-checking bench for the processor core
`timescale 1ns/1ps
module tb_cpu_core;
	// Drive side
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h00000000;
	logic [7:0] irq_i = 8'h00;
	// Design outputs and memory wires
	logic [31:0] dat_o;
	logic ack_o;
	logic [15:0] pm_addr_o;
	logic [15:0] pm_data_i;
	logic [15:0] dm_addr_o;
	logic [7:0] dm_wdata_o;
	logic dm_we_o;
	logic dm_re_o;
	logic [7:0] dm_rdata_i;
	logic irq_ack_o;
	logic [2:0] irq_num_o;
	logic flash_we_o; // Self-write port
	logic [15:0] flash_addr_o;
	logic [15:0] flash_data_o;
	// Counters and last read word
	int err_total = 0;
	int check_count = 0;
	logic [31:0] rd;
	int fw_cnt = 0; // Self-write pulses seen
	// Main code at 0x20: stack first, add, store, call, loop
	logic [15:0] prog [0:15] = '{16'h70ff, 16'h9fb0, 16'h7104, 16'h9fd1,
		16'h7005, 16'h7103, 16'h2211, 16'h8810, 16'h0100, 16'hd000,
		16'h0040, 16'h70ff, 16'h9f70, 16'h0003, 16'hc000, 16'h002e};
	// Source 2 handler at 0x50: X load, table read, two self writes
	logic [15:0] hnd [0:13] = '{16'h7a00, 16'h7b01, 16'h8292, 16'h8a12,
		16'h7ea1, 16'h7f00, 16'h0006, 16'h8800, 16'h0102, 16'h0005,
		16'hc000, 16'hf05c, 16'h0005, 16'h0002};
	// 250 MHz clock
	always #2 clk_i = ~clk_i;
	cpu_core dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
		.dat_i, .dat_o, .ack_o, .pm_addr_o, .pm_data_i, .dm_addr_o,
		.dm_wdata_o, .dm_we_o, .dm_re_o, .dm_rdata_i, .irq_i, .irq_ack_o,
		.irq_num_o, .flash_we_o, .flash_addr_o, .flash_data_o);
	cpu_mem_model mem_u (.clk_i, .pm_addr_i(pm_addr_o),
		.pm_data_o(pm_data_i), .dm_addr_i(dm_addr_o),
		.dm_wdata_i(dm_wdata_o), .dm_we_i(dm_we_o), .dm_re_i(dm_re_o),
		.dm_rdata_o(dm_rdata_i));
	// Count self-write pulses; only the boot copy may land
	always @(posedge clk_i) begin
		if (flash_we_o === 1'b1) fw_cnt++;
	end
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask
	// One classic Wishbone cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'h1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 64);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		chk("bus ack", 32'h00000001, {31'h0, ack_o});
	endtask
	// Wait for a fetch address, bounded
	task automatic wait_fetch(input logic [15:0] a);
		int n;
		n = 0;
		while (pm_addr_o !== a && n < 500) begin
			@(posedge clk_i);
			n++;
		end
		chk("fetch reach", {16'h0000, a}, {16'h0000, pm_addr_o});
	endtask
	// Closing verdict
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Straight code, ALU result, call and return
	task automatic t_run;
		wait_fetch(16'h002e);
		chk("alu store", 32'h00000008, {24'h0, mem_u.ram[16'h0100]});
		chk("ret low", 32'h0000002b, {24'h0, mem_u.ram[16'h04ff]});
		chk("ret high", 32'h00000000, {24'h0, mem_u.ram[16'h04fe]});
		wb(1'b0, 8'h08, 32'h00000000);
		chk("stack after ret", 32'h000004ff, rd);
		wb(1'b0, 8'h04, 32'h00000000);
		chk("sign", {31'h0, rd[19] ^ rd[18]}, {31'h0, rd[20]});
		chk("zero carry", 32'h00000000, {30'h0, rd[17:16]});
	endtask
	// Two sources pending, lower index served
	task automatic t_irq;
		int n;
		irq_i <= 8'h06;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (irq_ack_o !== 1'b1 && n < 200);
		chk("irq index", 32'h00000001, {29'h0, irq_num_o});
		irq_i <= 8'h00;
		repeat (4) @(posedge clk_i);
		wait_fetch(16'h002e);
		wb(1'b0, 8'h04, 32'h00000000);
		chk("enable back", 32'h00000001, {31'h0, rd[23]});
		wb(1'b0, 8'h08, 32'h00000000);
		chk("stack restored", 32'h000004ff, rd);
	endtask
	// Source 2: pointer load, table read, self writes from both sections
	task automatic t_mem;
		irq_i <= 8'h04;
		wait_fetch(16'h0051);
		irq_i <= 8'h00;
		wait_fetch(16'h002e);
		chk("ptr load", 32'h00000008, {24'h0, mem_u.ram[16'h0101]});
		chk("table read", 32'h0000007a, {24'h0, mem_u.ram[16'h0102]});
		chk("self writes", 32'h00000001, fw_cnt);
		chk("flash word", 32'h00a1007a, {flash_addr_o, flash_data_o});
	endtask
	// Reset value, unmapped and read-only places
	task automatic t_bus;
		wb(1'b0, 8'h00, 32'h00000000);
		chk("ctrl reset", 32'h00000001, rd);
		wb(1'b1, 8'h40, 32'hffffffff);
		wb(1'b0, 8'h40, 32'h00000000);
		chk("unmapped", 32'h00000000, rd);
		wb(1'b1, 8'h08, 32'h00001234);
		wb(1'b0, 8'h08, 32'h00000000);
		chk("stack read only", 32'h000004ff, rd);
		wb(1'b1, 8'h00, 32'h00000015);
		wb(1'b0, 8'h00, 32'h00000000);
		chk("ctrl locks", 32'h00000015, rd);
	endtask
	// Main sequence
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem_u.rom[i] = 16'h0000;
		end
		for (int i = 0; i < 16; i++) begin
			mem_u.rom[32 + i] = prog[i];
			if (i < 14) mem_u.rom[80 + i] = hnd[i];
		end
		mem_u.rom[0] = 16'hc000;
		mem_u.rom[1] = 16'h0020;
		mem_u.rom[4] = 16'h0002;
		mem_u.rom[6] = 16'hc000;
		mem_u.rom[7] = 16'h0050;
		mem_u.rom[64] = 16'h0001;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_run();
		t_irq();
		t_mem();
		t_bus();
		end_of_test();
	end
	// Watchdog against hangs
	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		end_of_test();
	end
endmodule
